// ---- sdc_pkg.sv ----
`default_nettype none
package sdc_pkg;
    // ----------------------------------------------------------------
    // widths, burst length and the A10 bit index
    // ----------------------------------------------------------------
    localparam int DW = 16;
    localparam int BAW = 2;
    localparam int RW = 12;
    localparam int CWD = 8;
    localparam int AW = 12;
    localparam int FW = 4;
    localparam int BEW = DW / 8;
    localparam int BURST = 4;
    localparam int A10 = 10;
    localparam int PIPEW = 8;
    localparam int CNTW = 5;
    localparam int SINW = 6;
    // ----------------------------------------------------------------
    // mode word and latency base
    // ----------------------------------------------------------------
    localparam logic [AW-1:0] MODE_CL3 = 12'h032;
    localparam logic [AW-1:0] MODE_CL2 = 12'h022;
    localparam logic [2:0] CL_BASE = 3'h2;
    // ----------------------------------------------------------------
    // spacing counter indices
    // ----------------------------------------------------------------
    localparam int C_RC = 0;
    localparam int C_RCD = 1;
    localparam int C_RP = 2;
    localparam int C_RAS = 3;
    localparam int C_RRD = 4;
    localparam int C_WR = 5;
    localparam int C_HZP = 6;
    localparam int C_RDRD = 7;
    localparam int C_RDPRE = 8;
    localparam int C_RDWR = 9;
    localparam int C_WRWR = 10;
    localparam int C_WRPRE = 11;
    localparam int C_WRRD = 12;
    localparam int NCNT = 13;
    // ----------------------------------------------------------------
    // checked events
    // ----------------------------------------------------------------
    localparam int E_ACT = 0;
    localparam int E_REF = 1;
    localparam int E_PRE = 2;
    localparam int E_RD = 3;
    localparam int E_WR = 4;
    localparam int NEV = 5;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    // {cs_b, ras_b, cas_b, we_b}
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
        CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_NOP = 4'h7, CMD_DSEL = 4'hF
    } sdc_cmd_t;
    typedef enum logic [2:0] {
        S_INIT = 3'h0, S_IPRE = 3'h1, S_MODE = 3'h3, S_IDLE = 3'h2,
        S_ACT = 3'h6, S_COL = 3'h7, S_PRE = 3'h5, S_REF = 3'h4
    } sdc_state_t;
    typedef struct packed {
        logic wr;
        logic [BAW-1:0] bank;
        logic [RW-1:0] row;
        logic [CWD-1:0] col;
        logic [1:0] last;
        logic [BEW-1:0] be;
        logic [BURST-1:0][DW-1:0] data;
    } sdc_req_t;
    typedef struct packed {
        logic casLatencySelect;
        logic [FW-1:0] refreshCycleField;
        logic [FW-1:0] rowToColumnField;
        logic [FW-1:0] prechargeTimeField;
        logic [FW-1:0] rowActiveMinField;
        logic [FW-1:0] bankToBankField;
        logic [FW-1:0] writeRecoveryField;
        logic [FW-1:0] prechargeFloatField;
        logic [FW-1:0] readReadGap;
        logic [FW-1:0] readPrechargeGap;
        logic [FW-1:0] readWriteGap;
        logic [FW-1:0] maskBeforeWriteGap;
        logic [FW-1:0] writeWriteGap;
        logic [FW-1:0] writePrechargeGap;
        logic [FW-1:0] writeReadGap;
    } sdc_tim_t;
endpackage : sdc_pkg
`default_nettype wire

// ---- sdc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic memClk,
    input wire sdc_tim_t tim,
    input wire logic refreshReq,
    output logic refreshDone,
    output logic initDone,
    input wire logic reqValid,
    output logic reqReady,
    input wire sdc_req_t req,
    output logic rdValid,
    output logic [DW-1:0] rdData,
    output logic sdCs_b,
    output logic sdRas_b,
    output logic sdCas_b,
    output logic sdWe_b,
    output logic [BAW-1:0] sdBa,
    output logic [AW-1:0] sdAddr,
    output logic [BEW-1:0] sdDqm,
    output logic [DW-1:0] sdDqOut,
    output logic sdDqOe,
    input wire logic [DW-1:0] sdDqIn
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ----------------------------------------------------------------
    // reset release and link sampling
    // ----------------------------------------------------------------
    logic [1:0] rstSync_ff;
    logic rstN;
    logic [2:0] mclk_ff;
    logic [DW-1:0] dq1_ff;
    logic [DW-1:0] dq2_ff;
    logic tick;
    logic fallTick;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) rstSync_ff <= 2'h0;
        else rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
    assign rstN = rstSync_ff[1];

    // data is sampled through the same two stages as the clock so both stay aligned
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            mclk_ff <= 3'h0;
            dq1_ff <= '0;
            dq2_ff <= '0;
        end else begin
            mclk_ff <= {mclk_ff[1:0], memClk};
            dq1_ff <= sdDqIn;
            dq2_ff <= dq1_ff;
        end
    end
    assign tick = mclk_ff[1] & ~mclk_ff[2];
    assign fallTick = ~mclk_ff[1] & mclk_ff[2];

    // ----------------------------------------------------------------
    // request buffer
    // ----------------------------------------------------------------
    sdc_req_t fifoMem_ff [DEPTH];
    logic [PW-1:0] wp_ff;
    logic [PW-1:0] rp_ff;
    logic [PW:0] fill_ff;
    logic push;
    logic pop;
    logic headValid;
    sdc_req_t head;

    assign reqReady = (fill_ff != (PW+1)'(DEPTH));
    assign headValid = (fill_ff != '0);
    assign head = fifoMem_ff[rp_ff];
    assign push = reqValid & reqReady;

    always_ff @(posedge clock) begin
        if (push) fifoMem_ff[wp_ff] <= req;
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            wp_ff <= '0;
            rp_ff <= '0;
            fill_ff <= '0;
        end else begin
            if (push) wp_ff <= (wp_ff == PW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
            if (pop) rp_ff <= (rp_ff == PW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
            if (push && !pop) fill_ff <= fill_ff + 1'b1;
            else if (pop && !push) fill_ff <= fill_ff - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // spacing counters
    // ----------------------------------------------------------------
    logic [NCNT-1:0] ld;
    logic [NCNT-1:0] z;
    logic [CNTW-1:0] lv [NCNT];
    logic [CNTW-1:0] gap_ff [NCNT];
    sdc_cmd_t cmd;
    logic isAct;
    logic isRd;
    logic isWr;
    logic isPre;
    logic isRef;
    logic isMrs;
    logic [1:0] wrLast_ff;

    assign isAct = tick & (cmd == CMD_ACT);
    assign isRd = tick & (cmd == CMD_RD);
    assign isWr = tick & (cmd == CMD_WR);
    assign isPre = tick & (cmd == CMD_PRE);
    assign isRef = tick & (cmd == CMD_REF);
    assign isMrs = tick & (cmd == CMD_MRS);

    // a counter loaded with N-1 at a command lets the dependent one go N ticks later
    assign lv[C_RC] = {1'b0, tim.refreshCycleField};
    assign lv[C_RCD] = {1'b0, tim.rowToColumnField};
    assign lv[C_RP] = {1'b0, tim.prechargeTimeField};
    assign lv[C_RAS] = {1'b0, tim.rowActiveMinField};
    assign lv[C_RRD] = {1'b0, tim.bankToBankField} + 5'h01;
    assign lv[C_WR] = {3'h0, head.last} + {1'b0, tim.writeRecoveryField};
    assign lv[C_HZP] = {1'b0, tim.prechargeFloatField};
    assign lv[C_RDRD] = {1'b0, tim.readReadGap};
    assign lv[C_RDPRE] = {1'b0, tim.readPrechargeGap};
    assign lv[C_RDWR] = {1'b0, tim.readWriteGap};
    assign lv[C_WRWR] = {1'b0, tim.writeWriteGap};
    assign lv[C_WRPRE] = {1'b0, tim.writePrechargeGap};
    assign lv[C_WRRD] = {1'b0, tim.writeReadGap};

    assign ld[C_RC] = isRef;
    assign ld[C_RCD] = isAct;
    assign ld[C_RP] = isPre | isMrs;
    assign ld[C_RAS] = isAct;
    assign ld[C_RRD] = isAct;
    assign ld[C_WR] = isWr;
    assign ld[C_HZP] = isPre;
    assign ld[C_RDRD] = isRd;
    assign ld[C_RDPRE] = isRd;
    assign ld[C_RDWR] = isRd;
    assign ld[C_WRWR] = isWr;
    assign ld[C_WRPRE] = isWr;
    assign ld[C_WRRD] = isWr;

    for (genvar i = 0; i < NCNT; i++) begin : g_gap
        always_ff @(posedge clock or negedge rstN) begin
            if (!rstN) gap_ff[i] <= '0;
            else if (ld[i]) gap_ff[i] <= lv[i];
            else if (tick && gap_ff[i] != '0) gap_ff[i] <= gap_ff[i] - 1'b1;
        end
        assign z[i] = (gap_ff[i] == '0);
    end

    // ----------------------------------------------------------------
    // page and read pipe state
    // ----------------------------------------------------------------
    sdc_state_t state_ff;
    sdc_state_t nxt_state;
    logic pageV_ff;
    logic [BAW-1:0] curBank_ff;
    logic [RW-1:0] curRow_ff;
    logic pall_ff;
    logic [PIPEW-1:0] rdPipe_ff;
    logic [SINW-1:0] maskCnt_ff;
    logic [1:0] beat_ff;
    logic wrAct_ff;
    logic wrBusy;
    logic hit;
    logic maskHold;
    logic maskOk;
    logic preOk;
    logic colOk;
    logic [2:0] clCyc;
    logic [PIPEW-1:0] want;

    // single open page; it closes only on a miss or a refresh
    assign hit = pageV_ff & (head.bank == curBank_ff) & (head.row == curRow_ff);
    assign clCyc = CL_BASE + {2'h0, tim.casLatencySelect};
    assign want = PIPEW'((5'h02 << head.last) - 5'h01);
    assign maskHold = (state_ff == S_COL) & headValid & head.wr & (rdPipe_ff != '0);
    assign maskOk = (rdPipe_ff == '0) | (maskCnt_ff > {2'h0, tim.maskBeforeWriteGap});
    assign preOk = z[C_RAS] & z[C_WR] & z[C_RDPRE] & z[C_WRPRE];
    // a column command may only cut surplus write beats, never one that the write burst still wants
    assign wrBusy = wrAct_ff & (beat_ff <= wrLast_ff);
    assign colOk = z[C_RCD] & ~wrBusy & (head.wr ? (z[C_WRWR] & z[C_RDWR] & z[C_HZP] & maskOk & (rdPipe_ff == '0))
                                                 : (z[C_RDRD] & z[C_WRRD]));
    assign pop = isRd | isWr;

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        cmd = CMD_NOP;
        case (state_ff)
            S_INIT: nxt_state = S_IPRE;
            S_IPRE: begin
                cmd = CMD_PRE;
                nxt_state = S_MODE;
            end
            S_MODE: if (z[C_RP] && z[C_RC]) begin
                cmd = CMD_MRS;
                nxt_state = S_IDLE;
            end
            S_IDLE: if (refreshReq) begin
                nxt_state = S_PRE;
            end else if (headValid) begin
                nxt_state = hit ? S_COL : (pageV_ff ? S_PRE : S_ACT);
            end
            S_PRE: if (preOk) begin
                cmd = CMD_PRE;
                nxt_state = pall_ff ? S_REF : S_ACT;
            end
            S_REF: if (z[C_RP] && z[C_RC]) begin
                cmd = CMD_REF;
                nxt_state = S_IDLE;
            end
            S_ACT: if (z[C_RP] && z[C_RC] && z[C_RRD]) begin
                cmd = CMD_ACT;
                nxt_state = S_COL;
            end
            S_COL: if (colOk) begin
                cmd = head.wr ? CMD_WR : CMD_RD;
                nxt_state = S_IDLE;
            end
            default: nxt_state = S_INIT;
        endcase
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            state_ff <= S_INIT;
            pall_ff <= 1'b1;
        end else if (tick) begin
            state_ff <= nxt_state;
            if (state_ff == S_IDLE) pall_ff <= refreshReq;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            pageV_ff <= 1'b0;
            curBank_ff <= '0;
            curRow_ff <= '0;
            initDone <= 1'b0;
        end else begin
            if (isAct) begin
                pageV_ff <= 1'b1;
                curBank_ff <= head.bank;
                curRow_ff <= head.row;
            end else if (isPre) begin
                pageV_ff <= 1'b0;
            end
            if (isMrs) initDone <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // command, address and data pins
    // ----------------------------------------------------------------
    logic [AW-1:0] nxt_addr;
    logic [BAW-1:0] nxt_ba;
    logic [3:0] cmd_ff;
    logic [BURST-1:0][DW-1:0] wrBuf_ff;
    logic [BEW-1:0] wrBe_ff;

    always_comb begin
        nxt_addr = '0;
        nxt_ba = curBank_ff;
        case (cmd)
            CMD_ACT: begin
                nxt_addr = head.row;
                nxt_ba = head.bank;
            end
            CMD_RD, CMD_WR: nxt_addr = {{(AW-CWD){1'b0}}, head.col};
            CMD_PRE: nxt_addr[A10] = pall_ff;
            CMD_MRS: nxt_addr = tim.casLatencySelect ? MODE_CL3 : MODE_CL2;
            default: nxt_addr = '0;
        endcase
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            cmd_ff <= CMD_DSEL;
            sdBa <= '0;
            sdAddr <= '0;
        end else if (tick) begin
            cmd_ff <= cmd;
            sdBa <= nxt_ba;
            sdAddr <= nxt_addr;
        end
    end
    assign {sdCs_b, sdRas_b, sdCas_b, sdWe_b} = cmd_ff;

    // a write burst drives data up to beat wrLast_ff and masks the rest through beat three, unless another column command cuts it
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            sdDqOut <= '0;
            sdDqOe <= 1'b0;
            sdDqm <= '0;
            wrBuf_ff <= '0;
            wrBe_ff <= '0;
            wrLast_ff <= 2'h0;
            beat_ff <= 2'h0;
            wrAct_ff <= 1'b0;
        end else if (isWr) begin
            sdDqOut <= head.data[0];
            sdDqOe <= 1'b1;
            sdDqm <= ~head.be;
            wrBuf_ff <= head.data;
            wrBe_ff <= head.be;
            wrLast_ff <= head.last;
            beat_ff <= 2'h1;
            wrAct_ff <= 1'b1;
        end else if (isRd) begin
            sdDqOe <= 1'b0;
            sdDqm <= '0;
            wrAct_ff <= 1'b0;
        end else if (tick && wrAct_ff) begin
            sdDqOut <= wrBuf_ff[beat_ff];
            sdDqOe <= (beat_ff <= wrLast_ff);
            sdDqm <= (beat_ff <= wrLast_ff) ? ~wrBe_ff : {BEW{1'b1}};
            beat_ff <= beat_ff + 2'h1;
            wrAct_ff <= (beat_ff != 2'h3);
        end else if (tick) begin
            sdDqOe <= 1'b0;
            sdDqm <= maskHold ? {BEW{1'b1}} : '0;
        end
    end

    // ----------------------------------------------------------------
    // read return
    // ----------------------------------------------------------------
    // beats are caught on the falling edge, half a period after the memory launched them
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rdPipe_ff <= '0;
            maskCnt_ff <= '0;
            rdValid <= 1'b0;
            rdData <= '0;
        end else begin
            if (isWr) rdPipe_ff <= '0;
            else if (isRd) rdPipe_ff <= (want << clCyc) | ((rdPipe_ff >> 1) & ~({PIPEW{1'b1}} << clCyc));
            else if (tick) rdPipe_ff <= rdPipe_ff >> 1;
            if (tick) maskCnt_ff <= maskHold ? maskCnt_ff + ((&maskCnt_ff) ? 6'h00 : 6'h01) : 6'h00;
            rdValid <= fallTick & rdPipe_ff[0];
            if (fallTick && rdPipe_ff[0]) rdData <= dq2_ff;
        end
    end

    assign refreshDone = isRef;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [SINW-1:0] since_ff [NEV];
    logic [NEV-1:0] ev;
    logic lastPall_ff;

    assign ev = {isWr, isRd, isPre, isRef, isAct};
    for (genvar e = 0; e < NEV; e++) begin : g_since
        always_ff @(posedge clock or negedge rstN) begin
            if (!rstN) since_ff[e] <= 6'h3F;
            else if (ev[e]) since_ff[e] <= 6'h01;
            else if (tick && since_ff[e] != 6'h3F) since_ff[e] <= since_ff[e] + 6'h01;
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) lastPall_ff <= 1'b0;
        else if (tick && cmd != CMD_NOP) lastPall_ff <= (cmd == CMD_PRE) & pall_ff;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    sequence wrIssue;
        isWr;
    endsequence
    sequence wrOnPins;
        sdDqOe && !sdWe_b && !sdCas_b && sdRas_b && !sdCs_b;
    endsequence

    refresh_spacing_a: assert property ((isAct || isRef || isMrs) |->
        since_ff[E_REF] >= {2'h0, tim.refreshCycleField} + 6'h01)
        else $error("refresh spacing too short");
    act_to_col_a: assert property ((isRd || isWr) |->
        since_ff[E_ACT] >= {2'h0, tim.rowToColumnField} + 6'h01)
        else $error("activate to column too short");
    pre_to_act_a: assert property ((isAct || isRef || isMrs) |->
        since_ff[E_PRE] >= {2'h0, tim.prechargeTimeField} + 6'h01)
        else $error("precharge recovery too short");
    row_open_min_a: assert property (isPre && pageV_ff |->
        since_ff[E_ACT] >= {2'h0, tim.rowActiveMinField} + 6'h01)
        else $error("row closed too early");
    act_to_act_a: assert property (isAct |->
        since_ff[E_ACT] >= {2'h0, tim.bankToBankField} + 6'h02)
        else $error("activate to activate too short");
    rd_to_wr_a: assert property (isWr |->
        since_ff[E_RD] >= {2'h0, tim.readWriteGap} + 6'h01)
        else $error("read to write too short");
    wr_to_pre_a: assert property (isPre |->
        since_ff[E_WR] >= {2'h0, tim.writePrechargeGap} + 6'h01)
        else $error("write to precharge too short");
    wr_data_launch_a: assert property (wrIssue |=> wrOnPins)
        else $error("write data not with command");
    mode_word_a: assert property (isMrs |=>
        sdAddr == (tim.casLatencySelect ? MODE_CL3 : MODE_CL2) && !sdCs_b && !sdRas_b && !sdCas_b && !sdWe_b)
        else $error("wrong mode word");
    pall_before_ref_a: assert property (isRef |-> lastPall_ff)
        else $error("refresh without all-bank precharge");
    init_first_a: assert property ((isAct || isRd || isWr) |-> initDone && $stable(initDone))
        else $error("access before mode set");
endmodule : sdc_ctrl
`default_nettype wire

// ---- sdc_sdram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// sdram partner: one array indexed by column, so rows alias
// ----------------------------------------------------------------
module sdc_sdram_model
    import sdc_pkg::*;
(
    input wire logic memClk,
    input wire logic [3:0] cmd,
    input wire logic [AW-1:0] sdAddr,
    input wire logic [BEW-1:0] sdDqm,
    input wire logic [DW-1:0] sdDqOut,
    input wire logic sdDqOe,
    output logic [DW-1:0] sdDqIn
);
    logic [DW-1:0] mem [256];
    logic [DW-1:0] drv = 16'h0;
    logic [2:0] cl = 3'h2;
    logic [7:0] rCol = 8'h0;
    logic [7:0] wCol = 8'h0;
    int rCnt = 99;
    int wCnt = 9;
    assign sdDqIn = sdDqOe ? sdDqOut : drv;
    initial for (int i = 0; i < 256; i++) mem[i] = {8'h5A, 8'(i)};
    // commands stand a whole period, so the middle of it is safe
    always @(negedge memClk) begin
        if (cmd == CMD_MRS) cl = sdAddr[6:4];
        if (cmd == CMD_RD) begin
            rCol = sdAddr[7:0];
            rCnt = 0;
        end
        if (cmd == CMD_WR) begin
            wCol = sdAddr[7:0];
            wCnt = 0;
            rCnt = 99;
        end
        for (int b = 0; b < BEW; b++) begin
            if (wCnt < 4 && sdDqOe && !sdDqm[b]) mem[8'(wCol + wCnt)][8*b +: 8] = sdDqOut[8*b +: 8];
        end
        if (wCnt < 4) wCnt++;
    end
    // released bus shows a toggling value, the inverse of the last beat every other period
    always @(posedge memClk) begin
        rCnt++;
        if (rCnt >= cl && rCnt < cl + 4) drv <= mem[8'(rCol + rCnt - cl)];
        else drv <= ~drv;
    end
endmodule : sdc_sdram_model
`default_nettype wire

// ---- sdram_command_timing_controller_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdram_command_timing_controller_tb
    import sdc_pkg::*;
;
    logic clock = 0, rst_b = 0, memClk = 0, refreshReq = 0, reqValid = 0, cl = 0, preAll = 0;
    logic refreshDone, initDone, reqReady, rdValid, sdCs_b, sdRas_b, sdCas_b, sdWe_b, sdDqOe;
    logic [DW-1:0] rdData, sdDqOut, sdDqIn;
    logic [BAW-1:0] sdBa, openBa;
    logic [AW-1:0] sdAddr;
    logic [BEW-1:0] sdDqm;
    logic [3:0] cmd, lastCmd;
    logic [DW-1:0] shadow [256];
    logic [DW-1:0] expQ [$];
    sdc_tim_t tim;
    sdc_req_t req = '0;
    int n_mismatch = 0, checks = 0, sAct = 99, sPre = 99, sRef = 99;
    assign cmd = {sdCs_b, sdRas_b, sdCas_b, sdWe_b};
    assign tim = '{cl, 4'h3, 4'h2, 4'h2, 4'h4, 4'h1, 4'h1, 4'h1, 4'h0, 4'h1, 4'(3 + cl), 4'(1 + cl), 4'h0, 4'h1,
                   4'h0};
    initial forever #2 clock = ~clock;
    initial begin
        #7;
        forever #40 memClk = ~memClk;
    end
    sdc_ctrl #(.DEPTH(2)) sdc_ctrl_inst (.clock(clock), .rst_b(rst_b), .memClk(memClk), .tim(tim),
        .refreshReq(refreshReq), .refreshDone(refreshDone), .initDone(initDone), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rdValid(rdValid), .rdData(rdData), .sdCs_b(sdCs_b), .sdRas_b(sdRas_b),
        .sdCas_b(sdCas_b), .sdWe_b(sdWe_b), .sdBa(sdBa), .sdAddr(sdAddr), .sdDqm(sdDqm), .sdDqOut(sdDqOut),
        .sdDqOe(sdDqOe), .sdDqIn(sdDqIn));
    sdc_sdram_model sdc_sdram_model_inst (.memClk(memClk), .cmd(cmd), .sdAddr(sdAddr), .sdDqm(sdDqm),
        .sdDqOut(sdDqOut), .sdDqOe(sdDqOe), .sdDqIn(sdDqIn));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic push(input logic wr, input logic [1:0] ba, input logic [RW-1:0] row, input logic [7:0] col,
                        input logic [1:0] last, input logic [1:0] be, input logic [DW-1:0] d);
        @(negedge clock);
        req = '{wr, ba, row, col, last, be, {d + 16'h3, d + 16'h2, d + 16'h1, d}};
        reqValid = 1;
        for (int n = 0; n < 5000 && reqReady !== 1'b1; n++) @(negedge clock);
        check("reqReady", 16'(reqReady), 16'h1);
        @(negedge clock);
        reqValid = 0;
        for (int i = 0; i <= last; i++) begin
            for (int b = 0; b < BEW; b++) if (wr && be[b]) shadow[col + i][8*b +: 8] = req.data[i][8*b +: 8];
            if (!wr) expQ.push_back(shadow[col + i]);
        end
    endtask : push
    // the quiet span afterwards lets surplus beats show up
    task automatic drain();
        for (int n = 0; n < 20000 && expQ.size() != 0; n++) @(negedge clock);
        check("drained", 16'(expQ.size()), 16'h0);
        repeat (400) @(negedge clock);
    endtask : drain
    // ----------------------------------------------------------------
    // observers
    // ----------------------------------------------------------------
    always @(negedge clock) begin
        if (rdValid === 1'b1 && expQ.size() == 0) check("extra beat", 16'h1, 16'h0);
        else if (rdValid === 1'b1) check("rdData", rdData, expQ.pop_front());
    end
    always @(negedge memClk) begin
        sAct++;
        sPre++;
        sRef++;
        if (rst_b && cmd == CMD_ACT) begin
            check("pre to act", 16'(sPre > tim.prechargeTimeField), 16'h1);
            check("ref to act", 16'(sRef > tim.refreshCycleField), 16'h1);
            check("act to act", 16'(sAct > tim.bankToBankField + 1), 16'h1);
            check("act after init", 16'(initDone), 16'h1);
            openBa = sdBa;
            sAct = 0;
        end
        if (rst_b && (cmd == CMD_RD || cmd == CMD_WR)) begin
            check("act to column", 16'(sAct > tim.rowToColumnField), 16'h1);
            check("column bank", 16'({sdAddr[A10], sdBa}), 16'(openBa));
        end
        if (rst_b && cmd == CMD_PRE) begin
            check("act to pre", 16'(sAct > tim.rowActiveMinField), 16'h1);
            preAll = sdAddr[A10];
            sPre = 0;
        end
        if (rst_b && cmd == CMD_REF) begin
            check("pre before ref", 16'(lastCmd == CMD_PRE && preAll), 16'h1);
            check("ref spacing", 16'(sPre > tim.prechargeTimeField && sRef > tim.refreshCycleField), 16'h1);
            sRef = 0;
        end
        if (rst_b && cmd == CMD_MRS) begin
            check("mode word", 16'(sdAddr), 16'(cl ? MODE_CL3 : MODE_CL2));
            sPre = 0;
        end
        if (cmd != CMD_NOP) lastCmd = cmd;
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #150us;
        n_mismatch++;
        results();
    end
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = {8'h5A, 8'(i)};
        for (int k = 0; k < 2; k++) begin
            @(negedge clock);
            rst_b = 0;
            cl = k[0];
            repeat (3) @(negedge clock);
            rst_b = 1;
            for (int n = 0; n < 20000 && initDone !== 1'b1; n++) @(negedge clock);
            check("initDone", 16'(initDone), 16'h1);
            push(1, 1, 5, 8'h10, 3, 2'h3, 16'h1100);
            push(0, 1, 5, 8'h10, 2, 2'h3, 16'h0);
            push(1, 1, 5, 8'h20, 1, 2'h1, 16'h2200 + 16'(k));
            push(0, 1, 5, 8'h20, 3, 2'h3, 16'h0);
            push(0, 2, 9, 8'h10, 0, 2'h3, 16'h0);
            drain();
            refreshReq = 1;
            for (int n = 0; n < 20000 && refreshDone !== 1'b1; n++) @(negedge clock);
            check("refreshDone", 16'(refreshDone), 16'h1);
            refreshReq = 0;
            push(0, 2, 9, 8'h20, 3, 2'h3, 16'h0);
            drain();
        end
        results();
    end
endmodule : sdram_command_timing_controller_tb
`default_nettype wire
